// File: rtl/tfem_top.sv
// Trigger and frame event monitor with AXI4-Lite registers.
// Assumes pg_out and frame_valid are aclk logic, trig_in is a pin.
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module tfem_top #(
	parameter int ADDR_W = 8,	// Bus address width
	parameter int QDEPTH = 8,	// Trigger queue depth
	parameter int TS_W   = 32	// Timestamp width
) (
	input  wire logic			aclk,
	input  wire logic			aresetn,
	input  wire logic [ADDR_W-1:0]		s_axi_awaddr,
	input  wire logic			s_axi_awvalid,
	output logic				s_axi_awready,
	input  wire logic [31:0]		s_axi_wdata,
	input  wire logic [3:0]			s_axi_wstrb,
	input  wire logic			s_axi_wvalid,
	output logic				s_axi_wready,
	output logic [1:0]			s_axi_bresp,
	output logic				s_axi_bvalid,
	input  wire logic			s_axi_bready,
	input  wire logic [ADDR_W-1:0]		s_axi_araddr,
	input  wire logic			s_axi_arvalid,
	output logic				s_axi_arready,
	output logic [31:0]			s_axi_rdata,
	output logic [1:0]			s_axi_rresp,
	output logic				s_axi_rvalid,
	input  wire logic			s_axi_rready,
	input  wire logic			trig_in,
	input  wire logic [tfem_pkg::NPG-1:0]	pg_out,
	input  wire logic [tfem_pkg::NCAM-1:0]	frame_valid,
	output logic				trigger_accept,
	output logic				trigger_overrun_event,
	output logic [tfem_pkg::NCAM-1:0]	frame_absent_event,
	output logic				output_pulse_event,
	output logic [TS_W-1:0]			event_ts
);
	localparam int QW = $clog2(QDEPTH + 1);	// Queue count width
	localparam logic [QW-1:0] QFULL = QW'(QDEPTH);	// Full level

	//------------------------------------------------------------
	// State
	//------------------------------------------------------------
	typedef struct packed {
		logic					aw_have;	// Write address held
		logic [ADDR_W-1:0]			awaddr;		// Held address
		logic					w_have;		// Write data held
		logic [31:0]				wdata;		// Held data
		logic [3:0]				wstrb;		// Held strobes
		logic					bvalid;		// Write answer
		logic [1:0]				bresp;		// Write status
		logic					rvalid;		// Read answer
		logic [31:0]				rdata;		// Read data
		logic [1:0]				rresp;		// Read status
		logic [1:0]				mode;		// Trigger mode
		logic					qen;		// Queue enable
		logic [31:0]				period;		// Least period
		logic [tfem_pkg::SELW-1:0]		oes;		// Output event source
		logic [tfem_pkg::NCAM*tfem_pkg::SELW-1:0] sss;	// Statistics sources
		logic [tfem_pkg::NCAM-1:0]		clr;		// Clear pulses
		logic [31:0]				gap;		// Cycles since issue
		logic [QW-1:0]				qcnt;		// Queued triggers
		logic					trig_prev;	// Last trigger level
		logic [tfem_pkg::NPG-1:0]		pg_prev;	// Last generator levels
		logic					accept;		// Trigger issued
		logic					ovr;		// Overrun strobe
		logic					opl;		// Output pulse strobe
		logic [TS_W-1:0]			ts;		// Free timestamp
		logic [TS_W-1:0]			ev_ts;		// Event timestamp
	} tfem_st_t;
	tfem_st_t	q;	// Current state
	tfem_st_t	d;	// Next state

	logic				trig_lvl;	// Synchronised trigger
	logic				trig_rise;	// Trigger start
	logic [tfem_pkg::NPG-1:0]	pg_rise;	// Generator pulse starts
	logic [tfem_pkg::NCAM-1:0]	sel_edge;	// Monitored edge per camera
	logic [tfem_pkg::NCAM-1:0]	flags;		// Missed-response flags
	logic [tfem_pkg::NCAM-1:0]	misses;		// Frame-absent strobes
	logic				wr_fire;	// Write executes
	logic				allow;		// Period elapsed

	//------------------------------------------------------------
	// Trigger pin and per-camera monitors
	//------------------------------------------------------------
	tfem_sync u_sync (
		.aclk		(aclk),
		.aresetn	(aresetn),
		.pin		(trig_in),
		.level		(trig_lvl)
	);

	assign trig_rise = trig_lvl & ~q.trig_prev;
	assign pg_rise   = pg_out & ~q.pg_prev;

	tfem_cam_if cam_if [tfem_pkg::NCAM] ();

	// One monitor per camera, each on its own chosen generator
	for (genvar i = 0; i < tfem_pkg::NCAM; i++)
	begin : g_cam
		assign sel_edge[i] = pg_rise[q.sss[i*tfem_pkg::SELW +: tfem_pkg::SELW]];
		assign cam_if[i].edge_p = sel_edge[i];
		assign cam_if[i].frame  = frame_valid[i];
		assign cam_if[i].clear  = q.clr[i];
		assign misses[i] = cam_if[i].miss;
		assign flags[i]  = cam_if[i].flag;
		tfem_cam_mon u_mon (
			.aclk		(aclk),
			.aresetn	(aresetn),
			.cam		(cam_if[i])
		);
	end

	//------------------------------------------------------------
	// Next state
	//------------------------------------------------------------
	assign wr_fire = q.aw_have && q.w_have && !q.bvalid;
	assign allow   = q.gap >= q.period;

	// Bus slave, registers, rate limiter and event strobes
	always_comb
	begin
		d = q;
		d.clr = '0;
		d.accept = 1'b0;
		d.ovr = 1'b0;
		d.opl = 1'b0;
		d.ts = q.ts + 1'b1;
		d.trig_prev = trig_lvl;
		d.pg_prev = pg_out;
		// Address and data are taken in either order
		if (s_axi_awvalid && s_axi_awready)
		begin
			d.aw_have = 1'b1;
			d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			d.w_have = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		// Both held: write and answer
		if (wr_fire)
		begin
			d.aw_have = 1'b0;
			d.w_have = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = tfem_pkg::RESP_OKAY;
			case (q.awaddr[7:0])
				tfem_pkg::CTRL_OFS:
				begin
					if (q.wstrb[0])
					begin
						d.mode = q.wdata[tfem_pkg::MODE_LSB +: 2];
						d.qen = q.wdata[tfem_pkg::QEN_BIT];
					end
				end
				tfem_pkg::PERIOD_OFS:
				begin
					for (int b = 0; b < 4; b++)
					begin
						if (q.wstrb[b])
						begin
							d.period[b*8 +: 8] = q.wdata[b*8 +: 8];
						end
					end
				end
				tfem_pkg::OES_OFS:
				begin
					if (q.wstrb[0])
					begin
						d.oes = q.wdata[tfem_pkg::SELW-1:0];
					end
				end
				tfem_pkg::SSS_OFS:
				begin
					if (q.wstrb[0])
					begin
						d.sss = q.wdata[tfem_pkg::NCAM*tfem_pkg::SELW-1:0];
					end
				end
				tfem_pkg::CLR_OFS:
				begin
					if (q.wstrb[0])
					begin
						d.clr = q.wdata[tfem_pkg::NCAM-1:0];
					end
				end
				tfem_pkg::FLAG_OFS, tfem_pkg::QLVL_OFS:
				begin
					d.bresp = tfem_pkg::RESP_OKAY;	// Read-only, write ignored
				end
				default:
				begin
					d.bresp = tfem_pkg::RESP_SLVERR;	// Unmapped
				end
			endcase
		end
		if (q.bvalid && s_axi_bready)
		begin
			d.bvalid = 1'b0;
		end
		// Read answers one cycle after address is taken
		if (s_axi_arvalid && s_axi_arready)
		begin
			d.rvalid = 1'b1;
			d.rdata = '0;
			d.rresp = tfem_pkg::RESP_OKAY;
			case (s_axi_araddr[7:0])
				tfem_pkg::CTRL_OFS:
				begin
					d.rdata[tfem_pkg::MODE_LSB +: 2] = q.mode;
					d.rdata[tfem_pkg::QEN_BIT] = q.qen;
				end
				tfem_pkg::PERIOD_OFS: d.rdata = q.period;
				tfem_pkg::OES_OFS: d.rdata[tfem_pkg::SELW-1:0] = q.oes;
				tfem_pkg::SSS_OFS: d.rdata[tfem_pkg::NCAM*tfem_pkg::SELW-1:0] = q.sss;
				tfem_pkg::FLAG_OFS: d.rdata[tfem_pkg::NCAM-1:0] = flags;
				tfem_pkg::CLR_OFS: d.rdata = '0;
				tfem_pkg::QLVL_OFS: d.rdata[QW-1:0] = q.qcnt;
				default: d.rresp = tfem_pkg::RESP_SLVERR;
			endcase
		end
		else if (q.rvalid && s_axi_rready)
		begin
			d.rvalid = 1'b0;
		end
		// Rate limiter: issue only once the least period has passed
		if (q.gap != 32'hFFFFFFFF)
		begin
			d.gap = q.gap + 1'b1;
		end
		if (trig_rise && q.qcnt == '0 && allow)
		begin
			d.accept = 1'b1;
		end
		else if (trig_rise && allow)
		begin
			d.accept = 1'b1;	// Oldest leaves, new one joins
		end
		else if (trig_rise)
		begin
			if (q.qen && q.qcnt != QFULL)
			begin
				d.qcnt = q.qcnt + 1'b1;
			end
			else
			begin
				d.ovr = (q.mode == tfem_pkg::MODE_EXT);
			end
		end
		else if (q.qcnt != '0 && allow)
		begin
			d.accept = 1'b1;
			d.qcnt = q.qcnt - 1'b1;
		end
		if (d.accept)
		begin
			d.gap = '0;
		end
		if (!q.qen)
		begin
			d.qcnt = '0;
		end
		// Output pulse start of the chosen generator
		d.opl = pg_rise[q.oes];
		// Stamp the cycle of any cause of an event
		if (trig_rise || (|sel_edge) || pg_rise[q.oes])
		begin
			d.ev_ts = q.ts;
		end
	end

	//------------------------------------------------------------
	// State register
	//------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			q <= '0;
			q.mode <= tfem_pkg::MODE_RST;
			q.period <= tfem_pkg::PERIOD_RST;
			q.oes <= tfem_pkg::OES_RST;
			q.sss <= tfem_pkg::SSS_RST;
		end
		else
		begin
			q <= d;
		end
	end

	//------------------------------------------------------------
	// Outputs
	//------------------------------------------------------------
	assign s_axi_awready = !q.aw_have && !q.bvalid;
	assign s_axi_wready  = !q.w_have && !q.bvalid;
	assign s_axi_bvalid  = q.bvalid;
	assign s_axi_bresp   = q.bresp;
	assign s_axi_arready = !q.rvalid;
	assign s_axi_rvalid  = q.rvalid;
	assign s_axi_rdata   = q.rdata;
	assign s_axi_rresp   = q.rresp;
	assign trigger_accept        = q.accept;
	assign trigger_overrun_event = q.ovr;
	assign frame_absent_event    = misses;
	assign output_pulse_event    = q.opl;
	assign event_ts              = q.ev_ts;

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	logic h_pend0;	// Helper: camera 0 awaits a frame

	// Independent copy of the pending state for camera 0
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			h_pend0 <= 1'b0;
		end
		else if (sel_edge[0])
		begin
			h_pend0 <= 1'b1;
		end
		else if (frame_valid[0])
		begin
			h_pend0 <= 1'b0;
		end
	end

	a_miss_two_edges: assert property (sel_edge[0] && h_pend0 && !frame_valid[0]
		|=> frame_absent_event[0] && flags[0])
		else $error("second edge without frame gave no miss");
	a_miss_has_cause: assert property (frame_absent_event[0]
		|-> $past(sel_edge[0] && h_pend0 && !frame_valid[0]))
		else $error("frame-absent event without cause");
	a_flag_clear_only: assert property ($fell(flags[0]) |-> $past(q.clr[0]))
		else $error("flag fell without clear");
	a_miss_beats_clear: assert property (q.clr[0] && sel_edge[0] && h_pend0
		&& !frame_valid[0] |=> flags[0])
		else $error("clear beat a same-cycle miss");
	a_ovr_rate: assert property (trig_rise && !allow && !q.qen
		&& q.mode == tfem_pkg::MODE_EXT |=> trigger_overrun_event)
		else $error("lost trigger gave no overrun");
	a_ovr_queue_full: assert property (trigger_overrun_event && q.qen
		|-> $past(q.qcnt) == QFULL)
		else $error("overrun with queue not full");
	a_ovr_mode: assert property (trigger_overrun_event
		|-> $past(q.mode) == tfem_pkg::MODE_EXT)
		else $error("overrun outside external mode");
	a_opl_start: assert property (pg_rise[q.oes] |=> output_pulse_event
		##1 !output_pulse_event)
		else $error("output pulse event missing or long");
	a_event_stamp: assert property (output_pulse_event
		|-> event_ts == $past(q.ts))
		else $error("event timestamp wrong");
	a_oes_reset: assert property ($past(!aresetn) |-> q.oes == tfem_pkg::OES_RST)
		else $error("output source not zero after reset");

	c_miss_seen: cover property (frame_absent_event[0]);
	c_overrun_queue: cover property (trigger_overrun_event && q.qen);
	c_pulse_gen3: cover property (q.oes == 2'h3 ##1 output_pulse_event);
	c_clear_and_miss: cover property (q.clr[0] && sel_edge[0] && h_pend0);
endmodule

// File: rtl/tfem_pkg.sv
// Constants of the trigger and frame event monitor.
// Assumes one 125 MHz clock and an AXI4-Lite register bus.
package tfem_pkg;
	//------------------------------------------------------------
	// Sizes
	//------------------------------------------------------------
	localparam int NCAM = 4;	// Cameras
	localparam int NPG  = 4;	// Pulse generators
	localparam int SELW = 2;	// Generator select width
	//------------------------------------------------------------
	// Register offsets
	//------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS   = 8'h00;	// Mode and queue enable
	localparam logic [7:0] PERIOD_OFS = 8'h04;	// Least output period
	localparam logic [7:0] OES_OFS    = 8'h08;	// Output event source
	localparam logic [7:0] SSS_OFS    = 8'h0C;	// Statistics sources
	localparam logic [7:0] FLAG_OFS   = 8'h10;	// Missed-response flags
	localparam logic [7:0] CLR_OFS    = 8'h14;	// Missed-response clear
	localparam logic [7:0] QLVL_OFS   = 8'h18;	// Queue level
	//------------------------------------------------------------
	// Fields and values
	//------------------------------------------------------------
	localparam int MODE_LSB = 0;	// Trigger mode field
	localparam int QEN_BIT  = 2;	// Queue enable bit
	localparam logic [1:0] MODE_EXT  = 2'h0;	// External input triggers
	localparam logic [1:0] MODE_GEN  = 2'h1;	// Internal generator
	localparam logic [1:0] MODE_SYNC = 2'h2;	// Synchronized
	localparam logic [1:0]  MODE_RST   = 2'h0;	// Mode after reset
	localparam logic [31:0] PERIOD_RST = 32'h0000007D;	// Period after reset
	localparam logic [1:0]  OES_RST    = 2'h0;	// Generator zero
	localparam logic [7:0]  SSS_RST    = 8'h00;	// All cameras on generator zero
	localparam logic [1:0]  RESP_OKAY   = 2'h0;	// AXI okay
	localparam logic [1:0]  RESP_SLVERR = 2'h2;	// AXI slave error
endpackage

// File: rtl/tfem_cam_if.sv
// Carrier between the top and one camera monitor.
// Assumes all signals are in the aclk domain.
`timescale 1ns/1ps
interface tfem_cam_if;
	logic	edge_p;	// Start edge of monitored pulse
	logic	frame;	// Valid frame arrived
	logic	clear;	// Clear command pulse
	logic	miss;	// Frame-absent strobe
	logic	flag;	// Sticky missed-response flag
	modport mon (input edge_p, frame, clear, output miss, flag);
	modport ctl (output edge_p, frame, clear, input miss, flag);
endinterface

// File: rtl/tfem_sync.sv
// Three-stage synchroniser for one pin input.
// Assumes the pin is asynchronous to aclk.
`timescale 1ns/1ps
module tfem_sync (
	input  wire logic	aclk,
	input  wire logic	aresetn,
	input  wire logic	pin,
	output logic		level
);
	typedef struct packed {
		logic	s1;	// First stage, read by s2 only
		logic	s2;	// Second stage
		logic	s3;	// Third stage
		logic	lvl;	// Settled level
	} tfem_sync_st_t;
	tfem_sync_st_t	q;	// Current state
	tfem_sync_st_t	d;	// Next state

	// A change counts once stages two and three agree
	always_comb
	begin
		d = q;
		d.s1 = pin;
		d.s2 = q.s1;
		d.s3 = q.s2;
		if (q.s2 == q.s3)
		begin
			d.lvl = q.s3;
		end
	end

	// State register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	assign level = q.lvl;
endmodule

// File: rtl/tfem_cam_mon.sv
// Missed frame response monitor for one camera.
// Assumes edge_p and frame are single-cycle aclk pulses.
`timescale 1ns/1ps
module tfem_cam_mon (
	input  wire logic	aclk,
	input  wire logic	aresetn,
	tfem_cam_if.mon		cam
);
	typedef struct packed {
		logic	pending;	// Edge seen, no frame yet
		logic	flag;		// Sticky flag
		logic	miss;		// Event strobe
	} tfem_cam_st_t;
	tfem_cam_st_t	q;	// Current state
	tfem_cam_st_t	d;	// Next state

	// Clear first, so that a miss in the same cycle wins
	always_comb
	begin
		d = q;
		d.miss = 1'b0;
		if (cam.clear)
		begin
			d.flag = 1'b0;
		end
		if (cam.edge_p)
		begin
			// A second edge with no frame between is a miss
			if (q.pending && !cam.frame)
			begin
				d.miss = 1'b1;
				d.flag = 1'b1;
			end
			d.pending = 1'b1;
		end
		else if (cam.frame)
		begin
			d.pending = 1'b0;
		end
	end

	// State register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	assign cam.miss = q.miss;
	assign cam.flag = q.flag;
endmodule

// File: dv/tfem_cam_model.sv
// Behavioural model of four cameras answering trigger pulses with frames.
// Assumes pg_out levels in the aclk domain; camera i listens on the line chosen in sel.
`timescale 1ns/1ps
module tfem_cam_model #(
	parameter int DLY = 5	// Frame latency in cycles
) (
	input  wire logic	aclk,
	input  wire logic	aresetn,
	input  wire logic [3:0]	pg_out,
	input  wire logic [7:0]	sel,
	input  wire logic [3:0]	drop,
	output logic [3:0]	frame_valid
);
	logic [3:0]	pg_q;	// Last generator levels
	int		cnt [4];	// Cycles left until a frame
	// One frame per trigger start unless told to drop it
	always @(posedge aclk)
	begin
		pg_q <= pg_out;
		for (int i = 0; i < 4; i++)
		begin
			frame_valid[i] <= aresetn && cnt[i] == 1;
			if (!aresetn)
				cnt[i] <= 0;
			else if (pg_out[sel[2*i+:2]] && !pg_q[sel[2*i+:2]] && !drop[i])
				cnt[i] <= DLY;
			else if (cnt[i] != 0)
				cnt[i] <= cnt[i] - 1;
		end
	end
endmodule

// File: dv/tb.sv
// Self-checking bench for the trigger and frame event monitor.
// Assumes tfem_pkg, the design and the camera model are compiled first.
`timescale 1ns/1ps
module tb;
	localparam int QD = 8;	// Queue depth under test
	localparam logic [33:0] OK = 34'h0;	// Okay answer, zero data
	logic		aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, trig_in;
	logic [7:0]	awaddr, araddr;
	logic [31:0]	wdata, rdata, ets, cyc;
	logic [3:0]	pg_out, drop, fv, fae, wstrb;
	logic [1:0]	bresp, rresp;
	logic		awready, wready, bvalid, arready, rvalid, ovr, ope, acc;
	logic [5:0]	ev;	// Event strobes seen
	logic [33:0]	exp_bus [$];	// Expected bus answers
	logic [5:0]	exp_ev [$];	// Expected event words
	int		n_fail, checks, n_acc;

	tfem_top #(.ADDR_W(8), .QDEPTH(QD), .TS_W(32)) tfem_top_inst (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.trig_in(trig_in), .pg_out(pg_out), .frame_valid(fv), .trigger_accept(acc),
		.trigger_overrun_event(ovr), .frame_absent_event(fae),
		.output_pulse_event(ope), .event_ts(ets));
	tfem_cam_model #(.DLY(5)) tfem_cam_model_inst (.aclk(aclk), .aresetn(aresetn),
		.pg_out(pg_out), .sel(8'hE4), .drop(drop), .frame_valid(fv));

	//------------------------------------------------------------
	// Checking
	//------------------------------------------------------------
	task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic test_done();
		if (n_fail == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Free-running cycle count, the timestamp that events should carry
	always @(posedge aclk)
		cyc <= aresetn ? cyc + 32'h1 : 32'h0;

	// Watcher: pops the oldest note whenever a result shows
	always @(negedge aclk)
	begin
		ev = {ovr, ope, fae};
		if (aresetn && ev !== 6'h00)
		begin
			chk("event", 34'(ev), 34'(exp_ev.size() ? exp_ev.pop_front() : 6'h00));
			chk("stamp", 34'(ets), 34'(cyc - 32'h1));
		end
		if (aresetn && acc)
			n_acc++;
		if ((bvalid && bready) || (rvalid && rready))
			chk("bus", bvalid ? {bresp, 32'h0} : {rresp, rdata},
				exp_bus.size() ? exp_bus.pop_front() : 34'h3FFFFFFFF);
	end

	//------------------------------------------------------------
	// Drivers
	//------------------------------------------------------------
	// One register access; waits for the answer under a bound
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [33:0] e);
		logic ta, tw, tr, done;
		exp_bus.push_back(e);
		if (w)
			{awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
		else
			{araddr, arvalid, rready} <= {a, 2'b11};
		done = 1'b0;
		for (int n = 0; n < 100 && !done; n++)
		begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tr = arvalid && arready;
			done = (bready && bvalid) || (rready && rvalid);
			@(posedge aclk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			if (tr)
				arvalid <= 1'b0;
			if (done)
				{bready, rready} <= 2'b00;
		end
		@(posedge aclk);	// Idle edge before the next request
		if (!done)
		begin
			n_fail++;
			test_done();
		end
	endtask

	// Input trigger pulse of three cycles
	task automatic trig(input int gap);
		trig_in <= 1'b1;
		repeat (3) @(posedge aclk);
		trig_in <= 1'b0;
		repeat (gap) @(posedge aclk);
	endtask

	// Generator pulse, rises twenty cycles apart
	task automatic pulse(input int g);
		pg_out[g] <= 1'b1;
		repeat (4) @(posedge aclk);
		pg_out[g] <= 1'b0;
		repeat (16) @(posedge aclk);
	endtask

	initial
	begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	initial
	begin
		repeat (100000) @(posedge aclk);
		n_fail++;
		test_done();
	end

	//------------------------------------------------------------
	// Main sequence
	//------------------------------------------------------------
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, trig_in} = 7'h00;
		{awaddr, araddr, wdata, pg_out, drop} = '0;
		wstrb = 4'hF;
		n_fail = 0;
		checks = 0;
		n_acc = 0;
		void'($urandom(32'h546C));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// Reset values, then the unmapped place
		for (int i = 0; i < 8; i++)
			bus(1'b0, 8'(4 * i), 32'h0, {i == 7 ? tfem_pkg::RESP_SLVERR : tfem_pkg::RESP_OKAY,
				i == 1 ? tfem_pkg::PERIOD_RST : 32'h0});
		bus(1'b1, 8'h1C, 32'h1, {tfem_pkg::RESP_SLVERR, 32'h0});
		// Camera i on generator i, camera 1 always and cameras 2 and 3 at random lose frames, camera 0 never
		drop <= (4'($urandom) | 4'h2) & 4'hE;
		bus(1'b1, tfem_pkg::SSS_OFS, 32'hE4, OK);
		for (int g = 0; g < 4; g++)
		begin
			bus(1'b1, tfem_pkg::OES_OFS, 32'(g), OK);
			bus(1'b0, tfem_pkg::OES_OFS, 32'h0, 34'(g));
			exp_ev.push_back(6'h10);
			pulse(g);
			exp_ev.push_back({2'b01, drop[g] ? 4'(1 << g) : 4'h0});
			pulse(g);
		end
		// Unselected generator and an answering camera stay silent
		pulse(0);
		pulse(0);
		// Sticky flags, ignored write, partial and full clear
		bus(1'b0, tfem_pkg::FLAG_OFS, 32'h0, 34'(drop));
		bus(1'b1, tfem_pkg::FLAG_OFS, 32'h0, OK);
		bus(1'b0, tfem_pkg::FLAG_OFS, 32'h0, 34'(drop));
		bus(1'b1, tfem_pkg::CLR_OFS, 32'h2, OK);
		bus(1'b0, tfem_pkg::FLAG_OFS, 32'h0, 34'(drop & 4'hD));
		bus(1'b0, tfem_pkg::CLR_OFS, 32'h0, OK);
		bus(1'b1, tfem_pkg::CLR_OFS, 32'hF, OK);
		bus(1'b0, tfem_pkg::FLAG_OFS, 32'h0, OK);
		// Clear and second unanswered edge in one cycle: the flag stays set
		drop <= 4'h1;
		pulse(0);
		exp_ev.push_back(6'h01);
		fork
			bus(1'b1, tfem_pkg::CLR_OFS, 32'h1, OK);
			begin
				repeat (2) @(posedge aclk);
				pulse(0);
			end
		join
		bus(1'b0, tfem_pkg::FLAG_OFS, 32'h0, 34'h1);
		// Fast triggers in each mode: all modes drop them, only external mode flags an overrun
		wstrb <= 4'h1;
		bus(1'b1, tfem_pkg::PERIOD_OFS, 32'hFFFFFF28, OK);
		wstrb <= 4'hF;
		bus(1'b0, tfem_pkg::PERIOD_OFS, 32'h0, 34'h28);
		for (int m = 0; m < 3; m++)
		begin
			bus(1'b1, tfem_pkg::CTRL_OFS, 32'(m), OK);
			repeat (60) @(posedge aclk);
			if (m == 0)
				exp_ev = {exp_ev, 6'h20, 6'h20};
			for (int k = 0; k < 4; k++)
				trig(k == 2 ? 27 : 7);
		end
		// Queue fills to its depth, the next trigger overflows
		bus(1'b1, tfem_pkg::PERIOD_OFS, 32'h3E8, OK);
		bus(1'b1, tfem_pkg::CTRL_OFS, 32'h4, OK);
		repeat (1100) @(posedge aclk);
		exp_ev.push_back(6'h20);
		repeat (QD + 2) trig(5);
		bus(1'b0, tfem_pkg::QLVL_OFS, 32'h0, 34'(QD));
		bus(1'b1, tfem_pkg::CTRL_OFS, 32'h0, OK);
		// Reset in mid-run returns the output source to generator zero
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		bus(1'b0, tfem_pkg::OES_OFS, 32'h0, OK);
		repeat (20) @(posedge aclk);
		chk("leftover", 34'(exp_ev.size() + exp_bus.size()), 34'h0);
		chk("accepts", 34'(n_acc), 34'h7);
		test_done();
	end
endmodule
